// ==== hdl/tcu_params.svh ====
// constants of the timer capture unit: register offsets, fields, reset values
// assumes an 8-bit register port with byte offsets of its own choosing
// Functional notes
// - a qualifying event copies the selected 16-bit timer count into the capture pair
// - pin triggers: every falling, every rising, every 4th or 16th rising edge
// - each capture sets the capture flag; only software clears it
// - a later capture overwrites an unread value with no warning
// - the pin level is watched whatever the pin direction
// - timer select bit 3 in the third timer control register picks the timer
// - prescaler counter clears when off, not in capture mode, or reset
// - switching between capture prescale modes keeps the prescaler count
// - with time-stamping, each stored received message is a capture event
// - time-stamp enable bit 4 of the can io control register selects message trigger
// - time-stamp codes: 0100/0101 every message, 0110 every 4th, 0111 every 16th
`ifndef TCU_PARAMS_SVH
`define TCU_PARAMS_SVH
`define TCU_A_CAP_LO   4'h0
`define TCU_A_CAP_HI   4'h1
`define TCU_A_CTRL     4'h2
`define TCU_A_T1_LO    4'h3
`define TCU_A_T1_HI    4'h4
`define TCU_A_T3_LO    4'h5
`define TCU_A_T3_HI    4'h6
`define TCU_A_T3_CTRL  4'h7
`define TCU_A_FLAGS    4'h8
`define TCU_A_ENABLES  4'h9
`define TCU_A_PRIO     4'ha
`define TCU_A_CANIO    4'hb
`define TCU_A_PINDIR   4'hc
`define TCU_B_FLAG     2
`define TCU_B_CAN_TIMESTAMP_ENABLE   4
`define TCU_B_T3SEL    3
`define TCU_B_T3ON     0
`define TCU_B_T1ON     0
`define TCU_M_FALL     4'h4
`define TCU_M_RISE     4'h5
`define TCU_M_RISE4    4'h6
`define TCU_M_RISE16   4'h7
`define TCU_PS4_LAST   4'h3
`define TCU_PS16_LAST  4'hf
`define TCU_RST_BYTE   8'h00
`define TCU_RST_DIR    1'b1
`endif

// ==== hdl/tcu_pkg.sv ====
// types of the timer capture unit
// assumes the constants header for all numbers
package tcu_pkg;
  typedef enum logic [1:0] {tcu_trig_none, tcu_trig_every, tcu_trig_four,
                            tcu_trig_sixteen} tcu_trig_t;
  typedef struct packed {
    logic [7:0]  cap_lo;
    logic [7:0]  cap_hi;
    logic [7:0]  ctrl;
    logic [15:0] t1;
    logic [15:0] t3;
    logic [7:0]  t1_ctrl;
    logic [7:0]  t3_ctrl;
    logic [7:0]  flags;
    logic [7:0]  enables;
    logic [7:0]  prio;
    logic [7:0]  canio;
    logic        pin_dir;
    logic        pin_latch;
    logic        sync1;
    logic        sync2;
    logic        pin_prev;
    logic [3:0]  presc;
    logic [7:0]  rdata;
    logic        irq;
    logic        pin_out;
    logic        pin_oe_n;
  } tcu_state_t;
endpackage

// ==== hdl/tcu_capture.sv ====
// timer capture unit: two 16-bit timers, capture pair, prescaler, flags
// assumes synchronous register port strobes and an asynchronous pin input
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "tcu_params.svh"
module tcu_capture
  import tcu_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe_n,
  input  wire logic       can_msg_rcvd,
  output logic            irq
);
  tcu_state_t s;
  tcu_state_t n;

  // decode of the capture mode field into a trigger kind
  function automatic tcu_trig_t trig_of(input logic [3:0] m);
    if (m == `TCU_M_FALL || m == `TCU_M_RISE) return tcu_trig_every;
    else if (m == `TCU_M_RISE4) return tcu_trig_four;
    else if (m == `TCU_M_RISE16) return tcu_trig_sixteen;
    else return tcu_trig_none;
  endfunction

  tcu_trig_t  trig;
  logic       use_can;
  logic       edge_seen;
  logic       fire;
  logic       capture;
  logic [15:0] src;

  // trigger selection, prescaling and capture decision
  always_comb begin
    trig    = trig_of(s.ctrl[3:0]);
    use_can = s.canio[`TCU_B_CAN_TIMESTAMP_ENABLE];
    if (use_can) begin
      edge_seen = can_msg_rcvd;
    end else if (s.ctrl[3:0] == `TCU_M_FALL) begin
      edge_seen = s.pin_prev & ~s.sync2;
    end else begin
      edge_seen = ~s.pin_prev & s.sync2;
    end
    fire = 1'b0;
    case (trig)
      tcu_trig_every:   fire = edge_seen;
      tcu_trig_four:    fire = edge_seen && s.presc[1:0] == `TCU_PS4_LAST;
      tcu_trig_sixteen: fire = edge_seen && s.presc == `TCU_PS16_LAST;
      default:          fire = 1'b0;
    endcase
    capture = fire;
    src = s.t3_ctrl[`TCU_B_T3SEL] ? s.t3 : s.t1;
  end

  // next state: register writes, timers, capture and flags
  always_comb begin
    n = s;
    n.pin_out  = s.pin_latch;
    n.pin_oe_n = s.pin_dir;
    // pin level seen whether driven or not
    n.sync1    = pin_in;
    n.sync2    = s.sync1;
    n.pin_prev = s.sync2;
    if (s.t1_ctrl[`TCU_B_T1ON]) n.t1 = s.t1 + 16'h0001;
    if (s.t3_ctrl[`TCU_B_T3ON]) n.t3 = s.t3 + 16'h0001;
    // prescaler: cleared when not capturing, kept across mode changes
    if (trig == tcu_trig_none) begin
      n.presc = 4'h0;
    end else if (edge_seen) begin
      n.presc = s.presc + 4'h1;
    end
    if (wr) begin
      if (addr == `TCU_A_CAP_LO) n.cap_lo = wdata;
      else if (addr == `TCU_A_CAP_HI) n.cap_hi = wdata;
      else if (addr == `TCU_A_CTRL) n.ctrl = wdata;
      else if (addr == `TCU_A_T1_LO) n.t1[7:0] = wdata;
      else if (addr == `TCU_A_T1_HI) n.t1[15:8] = wdata;
      else if (addr == `TCU_A_T3_LO) n.t3[7:0] = wdata;
      else if (addr == `TCU_A_T3_HI) n.t3[15:8] = wdata;
      else if (addr == `TCU_A_T3_CTRL) n.t3_ctrl = wdata;
      else if (addr == `TCU_A_FLAGS) n.flags = s.flags & ~wdata;
      else if (addr == `TCU_A_ENABLES) n.enables = wdata;
      else if (addr == `TCU_A_PRIO) n.prio = wdata;
      else if (addr == `TCU_A_CANIO) n.canio = wdata;
      else if (addr == `TCU_A_PINDIR) begin
        n.pin_dir   = wdata[1];
        n.pin_latch = wdata[0];
        n.t1_ctrl   = {7'h00, wdata[7]};
      end
    end
    // capture overwrites any unread value; set beats a software clear
    if (capture) begin
      n.cap_lo = src[7:0];
      n.cap_hi = src[15:8];
      n.flags[`TCU_B_FLAG] = 1'b1;
    end
    n.irq = |(n.flags & n.enables);
    n.rdata = `TCU_RST_BYTE;
    if (rd) begin
      if (addr == `TCU_A_CAP_LO) n.rdata = s.cap_lo;
      else if (addr == `TCU_A_CAP_HI) n.rdata = s.cap_hi;
      else if (addr == `TCU_A_CTRL) n.rdata = s.ctrl;
      else if (addr == `TCU_A_T1_LO) n.rdata = s.t1[7:0];
      else if (addr == `TCU_A_T1_HI) n.rdata = s.t1[15:8];
      else if (addr == `TCU_A_T3_LO) n.rdata = s.t3[7:0];
      else if (addr == `TCU_A_T3_HI) n.rdata = s.t3[15:8];
      else if (addr == `TCU_A_T3_CTRL) n.rdata = s.t3_ctrl;
      else if (addr == `TCU_A_FLAGS) n.rdata = s.flags;
      else if (addr == `TCU_A_ENABLES) n.rdata = s.enables;
      else if (addr == `TCU_A_PRIO) n.rdata = s.prio;
      else if (addr == `TCU_A_CANIO) n.rdata = s.canio;
      else if (addr == `TCU_A_PINDIR) n.rdata = {s.t1_ctrl[0], 5'h00, s.pin_dir, s.pin_latch};
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.pin_dir  <= `TCU_RST_DIR;
      s.pin_oe_n <= `TCU_RST_DIR;
    end else begin
      s <= n;
    end
  end

  assign rdata    = s.rdata;
  assign irq      = s.irq;
  assign pin_out  = s.pin_out;
  assign pin_oe_n = s.pin_oe_n;

  // a capture loads the selected timer and raises the flag next cycle
  capture_load_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    capture |=> {s.cap_hi, s.cap_lo} == $past(src) && s.flags[`TCU_B_FLAG])
    else $error("capture did not load timer");

  // flag is never cleared without a software write of one
  flag_sticky_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.flags[`TCU_B_FLAG] && !(wr && addr == `TCU_A_FLAGS) |=> s.flags[`TCU_B_FLAG])
    else $error("capture flag lost");

  // prescaler cleared outside capture modes
  presc_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    trig == tcu_trig_none |=> s.presc == 4'h0)
    else $error("prescaler not cleared");

  // every fourth rising edge fires
  four_edge_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    trig == tcu_trig_four && !use_can && edge_seen && s.presc[1:0] == 2'h3 |-> capture)
    else $error("fourth edge missed");

  // rising edge on registered samples fires in every-rising mode
  rise_edge_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.ctrl[3:0] == `TCU_M_RISE && !use_can && $rose(s.sync2) |-> capture)
    else $error("rising edge missed");

  // can message replaces pin events
  can_trig_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    use_can && trig == tcu_trig_every && can_msg_rcvd |-> capture)
    else $error("can message not captured");

  // timer select follows third timer control
  timer_sel_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    capture && s.t3_ctrl[`TCU_B_T3SEL] |=> {s.cap_hi, s.cap_lo} == $past(s.t3))
    else $error("wrong timer captured");

  // interrupt follows masked flags
  irq_level_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    irq == |($past(n.flags) & $past(n.enables)))
    else $error("interrupt level wrong");
endmodule

// ==== bench/tcu_far_model.sv ====
// far side of the capture unit: external pin source and message-stored pulse
// assumes the unit's pin latch and enable; the wire level is resolved here
`timescale 1ns/1ps
module tcu_far_model (
  input  wire logic sys_clk,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      pin_in,
  output logic      can_msg_rcvd
);
  logic ext_lvl = 1'b0;
  initial can_msg_rcvd = 1'b0;
  // the unit's latch wins while it drives, else the external source
  assign pin_in = pin_oe_n ? ext_lvl : pin_out;
  // external level changes just after an edge
  task automatic set_level(input logic v);
    @(posedge sys_clk);
    ext_lvl <= v;
  endtask
  // one pulse per message stored in a receive buffer
  task automatic msg_stored();
    @(posedge sys_clk);
    can_msg_rcvd <= 1'b1;
    @(posedge sys_clk);
    can_msg_rcvd <= 1'b0;
  endtask
endmodule

// ==== bench/timer_capture_unit_test.sv ====
// self-checking bench of the capture unit over its register port
// assumes the far-side model; both timers are left stopped so counts are exact
`timescale 1ns/1ps
`include "tcu_params.svh"
module timer_capture_unit_test;
  logic       sys_clk = 1'b0;
  logic       rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       pin_in, pin_out, pin_oe_n, can_msg_rcvd, irq;
  logic [15:0] last;
  int         fails = 0;
  int         n_tests = 0;
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  tcu_capture DUT (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .can_msg_rcvd(can_msg_rcvd), .irq(irq));
  tcu_far_model far (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in), .can_msg_rcvd(can_msg_rcvd));
  // verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    chk_byte(rdata, exp);
  endtask
  task automatic cap_is(input logic [15:0] v);
    rd_chk(`TCU_A_CAP_LO, v[7:0]);
    rd_chk(`TCU_A_CAP_HI, v[15:8]);
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(negedge sys_clk);
    chk_bit(irq, e);
  endtask
  // load a stopped timer: 1 or 3
  task automatic set_t(input bit t3, input logic [15:0] v);
    wr_reg(t3 ? `TCU_A_T3_LO : `TCU_A_T1_LO, v[7:0]);
    wr_reg(t3 ? `TCU_A_T3_HI : `TCU_A_T1_HI, v[15:8]);
  endtask
  // mode change with the interrupt masked and the stale flag cleared
  task automatic set_mode(input logic [3:0] m);
    wr_reg(`TCU_A_ENABLES, 8'h00);
    wr_reg(`TCU_A_CTRL, 8'h00);
    wr_reg(`TCU_A_CTRL, {4'h0, m});
    wr_reg(`TCU_A_FLAGS, 8'h04);
    wr_reg(`TCU_A_ENABLES, 8'h04);
  endtask
  task automatic edge_to(input logic v);
    far.set_level(v);
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic events(input bit can, input int n);
    repeat (n) if (can) far.msg_stored(); else begin edge_to(1'b1); edge_to(1'b0); end
    repeat (6) @(posedge sys_clk);
  endtask
  // n-1 events leave the pair alone, the n-th captures timer three
  task automatic prescale(input bit can, input logic [3:0] m, input int n,
                          input logic [15:0] v);
    set_mode(m);
    set_t(1'b1, v);
    events(can, n - 1);
    cap_is(last);
    if (can) events(1'b0, 2);
    cap_is(last);
    events(can, 1);
    cap_is(v);
    last = v;
  endtask
  initial begin
    #400us;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    rd_chk(`TCU_A_CTRL, `TCU_RST_BYTE);
    rd_chk(`TCU_A_PINDIR, {6'h00, `TCU_RST_DIR, 1'b0});
    rd_chk(4'hf, 8'h00);
    chk_bit(pin_oe_n, 1'b1);
    // falling edge captures timer one, flag and level interrupt follow
    set_t(1'b0, 16'h1111);
    set_mode(`TCU_M_FALL);
    edge_to(1'b1);
    set_t(1'b0, 16'h1234);
    edge_to(1'b0);
    cap_is(16'h1234);
    rd_chk(`TCU_A_FLAGS, 8'h04);
    irq_is(1'b1);
    wr_reg(`TCU_A_ENABLES, 8'h00);
    irq_is(1'b0);
    wr_reg(`TCU_A_ENABLES, 8'h04);
    irq_is(1'b1);
    wr_reg(`TCU_A_FLAGS, 8'h04);
    irq_is(1'b0);
    // rising only; a second capture overwrites while the flag stands
    set_t(1'b0, 16'h5678);
    set_mode(`TCU_M_RISE);
    edge_to(1'b1);
    set_t(1'b0, 16'h0abc);
    edge_to(1'b0);
    cap_is(16'h5678);
    edge_to(1'b1);
    cap_is(16'h0abc);
    edge_to(1'b0);
    // a port write on an output pin triggers a capture
    wr_reg(`TCU_A_PINDIR, 8'h00);
    set_t(1'b0, 16'h2468);
    chk_bit(pin_oe_n, 1'b0);
    wr_reg(`TCU_A_PINDIR, 8'h01);
    repeat (6) @(posedge sys_clk);
    chk_bit(pin_out, 1'b1);
    cap_is(16'h2468);
    wr_reg(`TCU_A_PINDIR, 8'h02);
    wr_reg(`TCU_A_T3_CTRL, 8'h08);
    last = 16'h2468;
    prescale(1'b0, `TCU_M_RISE4, 4, 16'habcd);
    prescale(1'b0, `TCU_M_RISE16, 16, 16'h4d4d);
    // two edges counted, then off: a fresh count of four
    events(1'b0, 2);
    wr_reg(`TCU_A_CTRL, 8'h00);
    wr_reg(`TCU_A_CTRL, {4'h0, `TCU_M_RISE4});
    set_t(1'b1, 16'h7001);
    events(1'b0, 3);
    cap_is(16'h4d4d);
    events(1'b0, 1);
    cap_is(16'h7001);
    // direct switch keeps the count: two more edges reach four
    wr_reg(`TCU_A_CTRL, {4'h0, `TCU_M_RISE16});
    events(1'b0, 2);
    wr_reg(`TCU_A_CTRL, {4'h0, `TCU_M_RISE4});
    set_t(1'b1, 16'h7002);
    events(1'b0, 1);
    cap_is(16'h7001);
    events(1'b0, 1);
    cap_is(16'h7002);
    last = 16'h7002;
    // message time-stamping in all four codes
    wr_reg(`TCU_A_CANIO, 8'h10);
    prescale(1'b1, `TCU_M_FALL, 1, 16'hc004);
    prescale(1'b1, `TCU_M_RISE, 1, 16'hc005);
    prescale(1'b1, `TCU_M_RISE4, 4, 16'hc006);
    prescale(1'b1, `TCU_M_RISE16, 16, 16'hc007);
    report_and_stop();
  end
endmodule
